// ===== sfd_decoder.sv
`timescale 1ns/100ps

// Summary of operation
// - opcode 06 sets the write latch flag; no further bytes.
// - opcode 04 clears the write latch flag; no further bytes.
// - after opcode 05 the status register shifts out.
// - after opcode 15 configuration one then configuration two shift out.
// - opcode 01 with one to three bytes loads status and configuration.
// - opcode 75 or b0 pauses a running program or erase.
// - opcode 7a or 30 lets the paused program or erase continue.
// - opcode b9 enters deep sleep.
// - opcode c0 plus exactly one byte stores the burst length.
// - opcode 9f returns maker code then the memory type and density code bytes.
// - opcode ab, three ignored bytes, then one signature byte.
// - opcode 90, two ignored bytes, one address byte, then codes.
// - address 00 gives maker code first, 01 gives device code first.
// - opcode b1 moves array accesses into the secured area.
// - opcode c1 returns array accesses to the main array.
// - opcode 2b shifts out the security register.
// - opcode 2f sets the lock-down bit, which then never changes.
// - soft reset needs arm opcode 66 completed before reset opcode 99.
// - any other command between arm and reset cancels the reset.
// - write-type commands ending off a byte boundary are rejected.
// - input sampled on rising clock, output driven on falling clock.
// - raising select during output ends the transfer.
// - program or erase start is ignored without the write latch flag.
module sfd_decoder
#(
    parameter logic [7:0] MAKER_CODE     = 8'h5a, // arbitrary value
    parameter logic [7:0] MEM_TYPE_CODE  = 8'h33, // arbitrary value
    parameter logic [7:0] DENSITY_CODE   = 8'h17, // arbitrary value
    parameter logic [7:0] DEVICE_CODE    = 8'h17, // arbitrary value
    parameter logic [7:0] SIGNATURE_CODE = 8'h17  // arbitrary value
)
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_n,
    input  wire logic       i_cs_n,
    input  wire logic       i_sclk,
    input  wire logic       i_si,
    input  wire logic       i_pe_busy,
    input  wire logic       i_pe_request,
    input  wire logic       i_pe_done,
    output logic            o_so,
    output logic            o_so_oe,
    output logic            o_write_latch_flag,
    output logic [7:0]      o_status_bits,
    output logic [7:0]      o_cfg1,
    output logic [7:0]      o_cfg2,
    output logic [7:0]      o_burst_len,
    output logic            o_pe_paused,
    output logic            o_deep_sleep,
    output logic            o_secure_area,
    output logic            o_lock_down,
    output logic            o_soft_reset,
    output logic            o_pe_start
);
    import sfd_pkg::*;

    logic       cs_n_s;
    logic       si_s;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_rise;

    sfd_pin_sync u_sync
    (
        .i_clk_sys   (i_clk_sys),
        .i_rst_n     (i_rst_n),
        .i_cs_n      (i_cs_n),
        .i_sclk      (i_sclk),
        .i_si        (i_si),
        .o_cs_n      (cs_n_s),
        .o_si        (si_s),
        .o_sclk_rise (sclk_rise),
        .o_sclk_fall (sclk_fall),
        .o_cs_rise   (cs_rise)
    );

    sfd_phase_t phase;
    sfd_phase_t next_phase;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic [2:0] byte_cnt;
    logic [2:0] next_byte_cnt;
    logic [7:0] in_shift;
    logic [7:0] next_in_shift;
    logic [7:0] opcode;
    logic [7:0] next_opcode;
    logic [7:0] val1;
    logic [7:0] next_val1;
    logic [7:0] val2;
    logic [7:0] next_val2;
    logic [7:0] val3;
    logic [7:0] next_val3;
    logic [1:0] out_idx;
    logic [1:0] next_out_idx;
    logic       next_so;
    logic       next_so_oe;
    logic       write_latch_flag;
    logic       next_wel;
    logic [7:0] stat;
    logic [7:0] next_stat;
    logic [7:0] next_cfg1;
    logic [7:0] next_cfg2;
    logic [7:0] next_burst;
    logic       next_paused;
    logic       next_deep;
    logic       next_secure;
    logic       next_lock;
    logic       arm;
    logic       next_arm;
    logic       next_soft_reset;
    logic       next_pe_start;
    logic [7:0] full_byte;
    logic [7:0] cur_op;
    logic [7:0] out_byte;
    logic       boundary_ok;

    function automatic logic [2:0] hdr_len(input logic [7:0] op);
        case (op)
            CMD_STATUS_READ, CMD_CONFIG_READ,
            CMD_STD_ID_READ, CMD_SECURITY_READ:          hdr_len = LEN_SINGLE;
            CMD_LEGACY_SIGNATURE, CMD_MAKER_DEVICE_READ: hdr_len = LEN_ADDR_HDR;
            default:                                     hdr_len = LEN_NONE;
        endcase
    endfunction : hdr_len

    function automatic logic [7:0] rd_byte(input logic [7:0] op, input logic [1:0] idx);
        logic [7:0] sts;
        logic [7:0] sec;
        sts = stat;
        sts[STS_LATCH_BIT] = write_latch_flag;
        sts[STS_BUSY_BIT]  = i_pe_busy;
        sec = 8'h00;
        sec[SEC_LOCK_BIT] = o_lock_down;
        case (op)
            CMD_STATUS_READ:       rd_byte = sts;
            CMD_CONFIG_READ:       rd_byte = idx[0] ? o_cfg2 : o_cfg1;
            CMD_STD_ID_READ:       rd_byte = (idx == 2'h0) ? MAKER_CODE :
                                             (idx == 2'h1) ? MEM_TYPE_CODE : DENSITY_CODE;
            CMD_LEGACY_SIGNATURE:  rd_byte = SIGNATURE_CODE;
            CMD_MAKER_DEVICE_READ: rd_byte = (idx[0] ^ val3[0]) ? DEVICE_CODE : MAKER_CODE;
            CMD_SECURITY_READ:     rd_byte = sec;
            default:               rd_byte = 8'h00;
        endcase
    endfunction : rd_byte

    always_comb
    begin
        next_phase      = phase;
        next_bit_cnt    = bit_cnt;
        next_byte_cnt   = byte_cnt;
        next_in_shift   = in_shift;
        next_opcode     = opcode;
        next_val1       = val1;
        next_val2       = val2;
        next_val3       = val3;
        next_out_idx    = out_idx;
        next_so         = o_so;
        next_so_oe      = o_so_oe;
        next_wel        = write_latch_flag;
        next_stat       = stat;
        next_cfg1       = o_cfg1;
        next_cfg2       = o_cfg2;
        next_burst      = o_burst_len;
        next_paused     = o_pe_paused;
        next_deep       = o_deep_sleep;
        next_secure     = o_secure_area;
        next_lock       = o_lock_down;
        next_arm        = arm;
        next_soft_reset = 1'b0;
        next_pe_start   = 1'b0;
        full_byte       = {in_shift[6:0], si_s};
        cur_op          = (byte_cnt == 3'h0) ? full_byte : opcode;
        out_byte        = rd_byte(opcode, out_idx);
        boundary_ok     = (bit_cnt == 3'h0) && (phase == PH_SHIFT_IN);

        // program or erase start only with the latch set
        if (i_pe_request && write_latch_flag && !o_pe_paused)
        begin
            next_pe_start = 1'b1;
        end
        if (i_pe_done)
        begin
            next_wel = 1'b0;
        end

        if (cs_n_s)
        begin
            next_phase    = PH_IDLE;
            next_bit_cnt  = 3'h0;
            next_byte_cnt = 3'h0;
            next_out_idx  = 2'h0;
            next_so_oe    = 1'b0;
            if (cs_rise && byte_cnt != 3'h0)
            begin
                if (opcode != CMD_SOFT_RESET_ARM)
                begin
                    next_arm = 1'b0;
                end
                if (o_deep_sleep && opcode == CMD_LEGACY_SIGNATURE)
                begin
                    next_deep = 1'b0;
                end
                if (boundary_ok && !o_deep_sleep)
                begin
                    case (opcode)
                        CMD_SET_WRITE_LATCH:
                            if (byte_cnt == LEN_SINGLE) next_wel = 1'b1;
                        CMD_CLEAR_WRITE_LATCH:
                            if (byte_cnt == LEN_SINGLE) next_wel = 1'b0;
                        CMD_STATUS_WRITE:
                            if (byte_cnt >= LEN_STATUS_MIN && byte_cnt <= LEN_STATUS_MAX && write_latch_flag && !i_pe_busy)
                            begin
                                next_stat = val1 & STS_WRITE_MASK;
                                if (byte_cnt >= LEN_STATUS_CFG) next_cfg1 = val2;
                                if (byte_cnt == LEN_STATUS_MAX) next_cfg2 = val3;
                                next_wel = 1'b0;
                            end
                        CMD_PAUSE_A, CMD_PAUSE_B:
                            if (byte_cnt == LEN_SINGLE)
                            begin
                                if (i_pe_busy) next_paused = 1'b1;
                                next_wel = 1'b0;
                            end
                        CMD_CONTINUE_A, CMD_CONTINUE_B:
                            if (byte_cnt == LEN_SINGLE) next_paused = 1'b0;
                        CMD_DEEP_SLEEP:
                            if (byte_cnt == LEN_SINGLE) next_deep = 1'b1;
                        CMD_BURST_LENGTH:
                            if (byte_cnt == LEN_BURST) next_burst = val1;
                        CMD_SECURE_ENTRY:
                            if (byte_cnt == LEN_SINGLE) next_secure = 1'b1;
                        CMD_SECURE_EXIT:
                            if (byte_cnt == LEN_SINGLE) next_secure = 1'b0;
                        CMD_SECURITY_LOCK:
                            if (byte_cnt == LEN_SINGLE)
                            begin
                                next_lock = 1'b1;
                                next_wel  = 1'b0;
                            end
                        CMD_SOFT_RESET_ARM:
                            if (byte_cnt == LEN_SINGLE) next_arm = 1'b1;
                            else next_arm = 1'b0;
                        CMD_SOFT_RESET:
                            if (byte_cnt == LEN_SINGLE && arm)
                            begin
                                next_soft_reset = 1'b1;
                                next_wel        = 1'b0;
                                next_paused     = 1'b0;
                                next_secure     = 1'b0;
                                next_burst      = BURST_RST;
                            end
                        default:
                            next_wel = next_wel;
                    endcase
                end
            end
        end
        else
        begin
            if (phase == PH_IDLE)
            begin
                next_phase = PH_SHIFT_IN;
            end
            // msb first, sampled on the rising clock
            if (sclk_rise && phase != PH_SHIFT_OUT)
            begin
                next_in_shift = full_byte;
                next_bit_cnt  = bit_cnt + 3'h1;
                if (bit_cnt == BIT_LAST)
                begin
                    case (byte_cnt)
                        3'h0:    next_opcode = full_byte;
                        3'h1:    next_val1   = full_byte;
                        3'h2:    next_val2   = full_byte;
                        3'h3:    next_val3   = full_byte;
                        default: next_val3   = val3;
                    endcase
                    next_byte_cnt = (byte_cnt == BYTE_CNT_MAX) ? BYTE_CNT_MAX : byte_cnt + 3'h1;
                    if ((!o_deep_sleep || cur_op == CMD_LEGACY_SIGNATURE) &&
                        hdr_len(cur_op) == byte_cnt + 3'h1)
                    begin
                        next_phase   = PH_SHIFT_OUT;
                        next_out_idx = 2'h0;
                    end
                end
            end
            // output bits change on the falling clock
            if (sclk_fall && phase == PH_SHIFT_OUT)
            begin
                next_so      = out_byte[BIT_LAST - bit_cnt];
                next_so_oe   = 1'b1;
                next_bit_cnt = bit_cnt + 3'h1;
                if (bit_cnt == BIT_LAST)
                begin
                    next_out_idx = (opcode == CMD_STD_ID_READ && out_idx == ID_LAST_IDX) ?
                                   2'h0 : out_idx + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            phase         <= PH_IDLE;
            bit_cnt       <= 3'h0;
            byte_cnt      <= 3'h0;
            in_shift      <= 8'h00;
            opcode        <= 8'h00;
            val1          <= 8'h00;
            val2          <= 8'h00;
            val3          <= 8'h00;
            out_idx       <= 2'h0;
            o_so          <= 1'b0;
            o_so_oe       <= 1'b0;
            write_latch_flag           <= 1'b0;
            stat          <= STATUS_RST;
            o_cfg1        <= CFG1_RST;
            o_cfg2        <= CFG2_RST;
            o_burst_len   <= BURST_RST;
            o_pe_paused   <= 1'b0;
            o_deep_sleep  <= 1'b0;
            o_secure_area <= 1'b0;
            o_lock_down   <= 1'b0;
            arm           <= 1'b0;
            o_soft_reset  <= 1'b0;
            o_pe_start    <= 1'b0;
        end
        else
        begin
            phase         <= next_phase;
            bit_cnt       <= next_bit_cnt;
            byte_cnt      <= next_byte_cnt;
            in_shift      <= next_in_shift;
            opcode        <= next_opcode;
            val1          <= next_val1;
            val2          <= next_val2;
            val3          <= next_val3;
            out_idx       <= next_out_idx;
            o_so          <= next_so;
            o_so_oe       <= next_so_oe;
            write_latch_flag           <= next_wel;
            stat          <= next_stat;
            o_cfg1        <= next_cfg1;
            o_cfg2        <= next_cfg2;
            o_burst_len   <= next_burst;
            o_pe_paused   <= next_paused;
            o_deep_sleep  <= next_deep;
            o_secure_area <= next_secure;
            o_lock_down   <= next_lock;
            arm           <= next_arm;
            o_soft_reset  <= next_soft_reset;
            o_pe_start    <= next_pe_start;
        end
    end

    assign o_write_latch_flag = write_latch_flag;
    assign o_status_bits      = stat;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    sequence s_single_done(logic [7:0] op);
        cs_rise && boundary_ok && byte_cnt == LEN_SINGLE && !o_deep_sleep && opcode == op;
    endsequence

    sequence s_burst_done;
        cs_rise && boundary_ok && byte_cnt == LEN_BURST && !o_deep_sleep && opcode == CMD_BURST_LENGTH;
    endsequence

    chk_latch_set_on: assert property (s_single_done(CMD_SET_WRITE_LATCH) |=> write_latch_flag)
        else $error("write latch not set");
    chk_latch_clear_on: assert property (s_single_done(CMD_CLEAR_WRITE_LATCH) |=> !write_latch_flag)
        else $error("write latch not cleared");
    chk_deep_sleep_entry: assert property (s_single_done(CMD_DEEP_SLEEP) |=> o_deep_sleep [*2])
        else $error("deep sleep not entered");
    chk_burst_len_store: assert property (s_burst_done |=> o_burst_len == $past(val1))
        else $error("burst length not stored");
    chk_lock_stays_set: assert property (o_lock_down |=> o_lock_down)
        else $error("lock-down bit changed");
    chk_reset_needs_arm: assert property (o_soft_reset |-> $past(arm) && !arm)
        else $error("soft reset without arm");
    chk_arm_cancel_other: assert property (cs_rise && byte_cnt != 3'h0 && opcode != CMD_SOFT_RESET_ARM
                                           |=> !arm)
        else $error("arm survived another command");
    chk_boundary_reject: assert property (cs_rise && bit_cnt != 3'h0 && phase == PH_SHIFT_IN && !i_pe_done
                                          |=> $stable(write_latch_flag) && $stable(o_deep_sleep) && $stable(o_burst_len))
        else $error("off-boundary command executed");
    chk_output_release: assert property (cs_rise |=> !o_so_oe ##1 !o_so_oe)
        else $error("output still driven after select");
    chk_start_gated: assert property (o_pe_start |-> $past(write_latch_flag) && !$past(o_pe_paused))
        else $error("program start without latch");
    chk_status_shift: assert property (sclk_fall && phase == PH_SHIFT_OUT && opcode == CMD_STATUS_READ
                                       && bit_cnt == 3'h6 |=> o_so == $past(write_latch_flag) && o_so_oe)
        else $error("status latch bit misplaced");

endmodule : sfd_decoder

// ===== sfd_host_model.sv
`timescale 1ns/100ps

module sfd_host_model
(
    input  wire logic i_clk_sys,
    input  wire logic i_so,
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_si
);
    initial
    begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_si   = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask : wt

    // one frame: nin bits sent msb first, then nout bits captured
    task automatic xfer(input logic [31:0] tx, input int nin, input int nout, output logic [23:0] rx);
        rx     = 24'h0;
        o_cs_n = 1'b0;
        wt(4);
        for (int i = 0; i < nin + nout; i++)
        begin
            if (i < nin)
                o_si = tx[nin - 1 - i];
            else
                o_si = ~o_si;
            wt(4);
            if (i >= nin)
                rx = {rx[22:0], i_so};
            o_sclk = 1'b1;
            wt(4);
            o_sclk = 1'b0;
        end
        wt(4);
        o_cs_n = 1'b1;
        o_si   = ~o_si;
        wt(10);
    endtask : xfer
endmodule : sfd_host_model

// ===== sfd_pin_sync.sv
`timescale 1ns/100ps

module sfd_pin_sync
(
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_cs_n,
    input  wire logic i_sclk,
    input  wire logic i_si,
    output logic      o_cs_n,
    output logic      o_si,
    output logic      o_sclk_rise,
    output logic      o_sclk_fall,
    output logic      o_cs_rise
);
    import sfd_pkg::*;

    logic [2:0] meta;
    logic [2:0] stable;
    logic [1:0] prev;
    logic [2:0] next_meta;
    logic [2:0] next_stable;
    logic [1:0] next_prev;

    // order: cs_n, sclk, si; edges compare the second stage with its delayed copy in prev
    always_comb
    begin
        next_meta   = {i_cs_n, i_sclk, i_si};
        next_stable = meta;
        next_prev   = stable[2:1];
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rst_n)
        begin
            meta   <= 3'h4;
            stable <= 3'h4;
            prev   <= 2'h2;
        end
        else
        begin
            meta   <= next_meta;
            stable <= next_stable;
            prev   <= next_prev;
        end
    end

    assign o_cs_n      = stable[2];
    assign o_si        = stable[0];
    assign o_sclk_rise = stable[1] & ~prev[0];
    assign o_sclk_fall = ~stable[1] & prev[0];
    assign o_cs_rise   = stable[2] & ~prev[1];

endmodule : sfd_pin_sync

// ===== sfd_pkg.sv
package sfd_pkg;

    // command opcodes
    localparam logic [7:0] CMD_SET_WRITE_LATCH   = 8'h06;
    localparam logic [7:0] CMD_CLEAR_WRITE_LATCH = 8'h04;
    localparam logic [7:0] CMD_STATUS_READ       = 8'h05;
    localparam logic [7:0] CMD_CONFIG_READ       = 8'h15;
    localparam logic [7:0] CMD_STATUS_WRITE      = 8'h01;
    localparam logic [7:0] CMD_PAUSE_A           = 8'h75;
    localparam logic [7:0] CMD_PAUSE_B           = 8'hb0;
    localparam logic [7:0] CMD_CONTINUE_A        = 8'h7a;
    localparam logic [7:0] CMD_CONTINUE_B        = 8'h30;
    localparam logic [7:0] CMD_DEEP_SLEEP        = 8'hb9;
    localparam logic [7:0] CMD_BURST_LENGTH      = 8'hc0;
    localparam logic [7:0] CMD_STD_ID_READ       = 8'h9f;
    localparam logic [7:0] CMD_LEGACY_SIGNATURE  = 8'hab;
    localparam logic [7:0] CMD_MAKER_DEVICE_READ = 8'h90;
    localparam logic [7:0] CMD_SECURE_ENTRY      = 8'hb1;
    localparam logic [7:0] CMD_SECURE_EXIT       = 8'hc1;
    localparam logic [7:0] CMD_SECURITY_READ     = 8'h2b;
    localparam logic [7:0] CMD_SECURITY_LOCK     = 8'h2f;
    localparam logic [7:0] CMD_NO_OPERATION      = 8'h00;
    localparam logic [7:0] CMD_SOFT_RESET_ARM    = 8'h66;
    localparam logic [7:0] CMD_SOFT_RESET        = 8'h99;

    // frame lengths in bytes, opcode included
    localparam logic [2:0] LEN_SINGLE     = 3'h1;
    localparam logic [2:0] LEN_BURST      = 3'h2;
    localparam logic [2:0] LEN_STATUS_MIN = 3'h2;
    localparam logic [2:0] LEN_STATUS_CFG = 3'h3;
    localparam logic [2:0] LEN_STATUS_MAX = 3'h4;
    localparam logic [2:0] LEN_ADDR_HDR   = 3'h4;
    localparam logic [2:0] LEN_NONE       = 3'h0;
    localparam logic [2:0] BYTE_CNT_MAX   = 3'h7;
    localparam logic [2:0] BIT_LAST       = 3'h7;
    localparam logic [1:0] ID_LAST_IDX    = 2'h2;

    // field positions and reset values
    localparam int         STS_BUSY_BIT    = 0;
    localparam int         STS_LATCH_BIT   = 1;
    localparam int         SEC_LOCK_BIT    = 1;
    localparam logic [7:0] STS_WRITE_MASK  = 8'hfc;
    localparam logic [7:0] STATUS_RST      = 8'h00;
    localparam logic [7:0] CFG1_RST        = 8'h00;
    localparam logic [7:0] CFG2_RST        = 8'h00;
    localparam logic [7:0] BURST_RST       = 8'h00;

    typedef enum logic [1:0]
    {
        PH_IDLE      = 2'b00,
        PH_SHIFT_IN  = 2'b01,
        PH_SHIFT_OUT = 2'b10
    } sfd_phase_t;

endpackage : sfd_pkg

// ===== tb_top.sv
`timescale 1ns/100ps

module tb_top;
    import sfd_pkg::*;
    // arbitrary values
    localparam logic [7:0] MK = 8'h3c, TY = 8'h4d, DN = 8'h5e, DV = 8'h6f, SG = 8'h71;
    logic        clk_sys = 1'b0, rst_n = 1'b0, pe_busy = 1'b0, pe_req = 1'b0, pe_done = 1'b0;
    logic        cs_n, sclk, si, so, so_oe, latch, pause, sleep, secure, lock, srst, pe_start;
    logic [7:0]  sts, cfg1, cfg2, burst, b1, b2, b3, st;
    logic [23:0] rx;
    int          n_errors = 0, comparisons = 0, n_srst = 0, n_start = 0, seed = 85;

    always #50 clk_sys = ~clk_sys;

    // released output shows the inverse of its last bit
    sfd_host_model u_host (.i_clk_sys(clk_sys), .i_so(so_oe ? so : ~so), .o_cs_n(cs_n), .o_sclk(sclk), .o_si(si));

    sfd_decoder #(.MAKER_CODE(MK), .MEM_TYPE_CODE(TY), .DENSITY_CODE(DN), .DEVICE_CODE(DV), .SIGNATURE_CODE(SG))
    u_dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_sclk(sclk), .i_si(si), .i_pe_busy(pe_busy),
           .i_pe_request(pe_req), .i_pe_done(pe_done), .o_so(so), .o_so_oe(so_oe), .o_write_latch_flag(latch),
           .o_status_bits(sts), .o_cfg1(cfg1), .o_cfg2(cfg2), .o_burst_len(burst), .o_pe_paused(pause),
           .o_deep_sleep(sleep), .o_secure_area(secure), .o_lock_down(lock), .o_soft_reset(srst),
           .o_pe_start(pe_start));

    always @(negedge clk_sys)
    begin
        n_srst  += (srst === 1'b1);
        n_start += (pe_start === 1'b1);
    end

    function automatic logic [7:0] sts_exp(input logic [7:0] s, input logic l, input logic b);
        return {s[7:2], l, b};
    endfunction : sts_exp

    function automatic logic [15:0] maker_device_read_cmd_exp(input logic a);
        return a ? {DV, MK} : {MK, DV};
    endfunction : maker_device_read_cmd_exp

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cmd(input logic [31:0] tx, input int nin, input int nout = 0);
        u_host.xfer(tx, nin, nout, rx);
    endtask : cmd

    task automatic pe_pulse(input logic r, input logic d);
        pe_req  = r;
        pe_done = d;
        @(negedge clk_sys);
        pe_req  = 1'b0;
        pe_done = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask : pe_pulse

    task automatic test_done;
        if (n_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    initial
    begin
        #5_000_000;
        n_errors++;
        test_done();
    end

    initial
    begin
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk({latch, sleep, secure, lock, pause, cfg1, burst}, 24'h0);
        cmd(CMD_SET_WRITE_LATCH, 8);
        chk(latch, 1'b1);
        cmd(CMD_CLEAR_WRITE_LATCH, 8);
        chk(latch, 1'b0);
        repeat (2)
        begin
            b1 = 8'($random(seed));
            b2 = 8'($random(seed));
            b3 = 8'($random(seed));
            cmd(CMD_SET_WRITE_LATCH, 8);
            cmd({CMD_STATUS_WRITE, b1, b2, b3}, 32);
            st = b1 & STS_WRITE_MASK;
            chk({sts, cfg1, cfg2}, {st, b2, b3});
            chk(latch, 1'b0);
            pe_busy = 1'($random(seed));
            cmd(CMD_STATUS_READ, 8, 8);
            chk(rx[7:0], sts_exp(st, 1'b0, pe_busy));
            pe_busy = 1'b0;
            cmd(CMD_CONFIG_READ, 8, 16);
            chk(rx[15:0], {b2, b3});
        end
        b1 = 8'($random(seed));
        cmd({CMD_BURST_LENGTH, b1}, 16);
        chk(burst, b1);
        cmd({CMD_BURST_LENGTH, ~b1[7:1]}, 15);
        chk(burst, b1);
        cmd(CMD_NO_OPERATION, 8);
        chk({latch, burst, sts}, {1'b0, b1, st});
        cmd(CMD_STD_ID_READ, 8, 24);
        chk(rx, {MK, TY, DN});
        cmd({CMD_LEGACY_SIGNATURE, 24'($random(seed))}, 32, 8);
        chk(rx[7:0], SG);
        for (int a = 0; a < 2; a++)
        begin
            cmd({CMD_MAKER_DEVICE_READ, 16'($random(seed)), 8'(a)}, 32, 16);
            chk(rx[15:0], maker_device_read_cmd_exp(a[0]));
        end
        cmd(CMD_SECURE_ENTRY, 8);
        chk(secure, 1'b1);
        cmd(CMD_SECURE_EXIT, 8);
        chk(secure, 1'b0);
        for (int k = 0; k < 2; k++)
        begin
            pe_busy = 1'b1;
            cmd(k ? CMD_PAUSE_B : CMD_PAUSE_A, 8);
            chk(pause, 1'b1);
            cmd(k ? CMD_CONTINUE_B : CMD_CONTINUE_A, 8);
            chk(pause, 1'b0);
            pe_busy = 1'b0;
        end
        pe_pulse(1'b1, 1'b0);
        cmd(CMD_SET_WRITE_LATCH, 8);
        pe_pulse(1'b1, 1'b0);
        chk(24'(n_start), 24'd1);
        pe_pulse(1'b0, 1'b1);
        chk(latch, 1'b0);
        cmd(CMD_SECURITY_LOCK, 8);
        chk(lock, 1'b1);
        cmd(CMD_SECURITY_READ, 8, 8);
        chk(rx[7:0], 8'h01 << SEC_LOCK_BIT);
        cmd(CMD_SET_WRITE_LATCH, 8);
        cmd(CMD_SOFT_RESET_ARM, 8);
        cmd(CMD_SOFT_RESET, 8);
        chk(24'(n_srst), 24'd1);
        chk({latch, lock}, 2'b01);
        cmd(CMD_SOFT_RESET_ARM, 8);
        cmd(CMD_NO_OPERATION, 8);
        cmd(CMD_SOFT_RESET, 8);
        chk(24'(n_srst), 24'd1);
        cmd(CMD_SET_WRITE_LATCH, 8);
        cmd(CMD_STATUS_READ, 8, 8);
        chk(rx[7:0], sts_exp(st, 1'b1, 1'b0));
        cmd(CMD_DEEP_SLEEP, 8);
        chk(sleep, 1'b1);
        cmd(CMD_CLEAR_WRITE_LATCH, 8);
        chk(latch, 1'b1);
        cmd({CMD_LEGACY_SIGNATURE, 24'h0}, 32, 8);
        chk({sleep, rx[7:0]}, {1'b0, SG});
        test_done();
    end
endmodule : tb_top
